// ### src/block_transfer_dma.sv
// block transfer controller started by the conversion-end event
// assumes a memory slave that answers each request with a one-cycle mem_ack
// Notes on behaviour
// - conversion end sets the flag and requests activation.
// - on activation the vector entry for the vector number is read first.
// - transfer information is fetched from the address in the vector, then data moves.
// - each transferred data unit decrements the block size counter.
// - each finished block decrements the block count.
// - at block end the transfer information is written back to memory.
// - after write-back, a block count of zero means all blocks are done.
// - blocks remaining: enable stays set, flag cleared, no CPU interrupt.
// - last block: enable cleared, flag kept, interrupt passed to the CPU.
`timescale 1ns/10ps
module block_transfer_dma
	import bdma_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        conv_done,
	output logic             mem_req,
	output logic             mem_we,
	output logic      [31:0] mem_addr,
	output logic      [31:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	output logic             cpu_irq
);
	state_t      state;
	logic        transfer_enable_bit;
	logic        conversion_end_flag;
	logic [31:0] vec_base;
	logic [7:0]  vec_num;
	logic [2:0]  idx;
	logic [31:0] info_addr;
	logic [4:0]  mode;
	logic [31:0] src;
	logic [31:0] dst;
	logic [31:0] src_init;
	logic [31:0] dst_init;
	logic [15:0] block_size_counter;
	logic [15:0] block_size_reload;
	logic [15:0] block_count;
	logic [15:0] rd_left;
	logic        conv_rise;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [31:0] fifo_out_data;

	// conversion-end pin into the clock domain
	edge_sync u_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.async_in (conv_done),
		.rise     (conv_rise)
	);

	// register port decode
	wire         ctrl_wr   = reg_wr && (reg_addr == REG_CTRL);
	wire         sw_clr    = ctrl_wr && !reg_wdata[CTRL_FLAG_BIT];
	wire [31:0]  vec_addr  = vec_base + {22'h0, vec_num, 2'h0};
	wire         area_dst  = mode[MODE_AREA_BIT];

	// sequencing conditions
	wire         activate  = (state == S_IDLE) && transfer_enable_bit && conversion_end_flag;
	wire         idle_bus  = !mem_req;
	wire         rd_issue  = (state == S_READ) && idle_bus && (rd_left != 16'h0) && fifo_in_ready;
	wire         rd_turn   = (state == S_READ) && idle_bus && !rd_issue;
	wire         block_end = (state == S_WRITE) && idle_bus && (block_size_counter == 16'h0);
	wire         wr_issue  = (state == S_WRITE) && idle_bus && !block_end && fifo_out_valid;
	wire         wr_turn   = (state == S_WRITE) && idle_bus && !block_end && !fifo_out_valid;
	wire         bk_issue  = (state == S_BACK) && idle_bus && (idx != INFO_END);
	wire         back_done = (state == S_BACK) && idle_bus && (idx == INFO_END);
	wire         last_blk  = (block_count == 16'h0);
	wire         fifo_push = (state == S_READ) && mem_ack;

	// write-back word selection
	wire [31:0]  back_word = (idx == INFO_SRC)  ? src :
	                         (idx == INFO_DST)  ? dst :
	                         (idx == INFO_SIZE) ? {block_size_reload, block_size_counter} :
	                                              {16'h0, block_count};

	// next values of the flag and enable bit
	wire         hw_flag_clr = back_done && !last_blk;
	wire         hw_en_clr   = back_done && last_blk;
	wire         next_flag   = conv_rise || (conversion_end_flag && !sw_clr && !hw_flag_clr);
	wire         next_en     = ctrl_wr ? reg_wdata[CTRL_EN_BIT] : (transfer_enable_bit && !hw_en_clr);

	// address step by progression code
	function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m);
		step = (m == AM_INC) ? a + WORD_STEP : (m == AM_DEC) ? a - WORD_STEP : a;
	endfunction : step

	// data buffer between source reads and destination writes
	word_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.srst      (srst),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   (mem_rdata),
		.out_valid (fifo_out_valid),
		.out_ready (wr_issue),
		.out_data  (fifo_out_data)
	);

	// flag, enable, interrupt and software registers
	always_ff @(posedge core_clk) begin
		if (srst) begin
			transfer_enable_bit <= 1'b0;
			conversion_end_flag <= 1'b0;
			cpu_irq             <= 1'b0;
			vec_base            <= VBASE_RESET;
			vec_num             <= VNUM_RESET;
		end else begin
			transfer_enable_bit <= next_en;
			conversion_end_flag <= next_flag;
			cpu_irq             <= next_flag && !next_en;
			if (reg_wr && (reg_addr == REG_VBASE)) begin
				vec_base <= reg_wdata;
			end
			if (reg_wr && (reg_addr == REG_VNUM)) begin
				vec_num <= reg_wdata[7:0];
			end
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL:   reg_rdata <= {30'h0, conversion_end_flag, transfer_enable_bit};
				REG_VBASE:  reg_rdata <= vec_base;
				REG_VNUM:   reg_rdata <= {24'h0, vec_num};
				REG_STATUS: reg_rdata <= {block_count, 10'h0, state};
				default:    reg_rdata <= 32'h0;
			endcase
		end
	end

	// memory request: held until acknowledged
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= 32'h0;
			mem_wdata <= 32'h0;
		end else if (mem_ack) begin
			mem_req <= (state == S_VEC) || ((state == S_INFO) && (idx != INFO_CNT));
			mem_we  <= 1'b0;
			if (state == S_VEC) begin
				mem_addr <= mem_rdata;
			end else begin
				mem_addr <= info_addr + {27'h0, idx + 3'h1, 2'h0};
			end
		end else if (activate) begin
			mem_req  <= 1'b1;
			mem_we   <= 1'b0;
			mem_addr <= vec_addr;
		end else if (rd_issue) begin
			mem_req  <= 1'b1;
			mem_we   <= 1'b0;
			mem_addr <= src;
		end else if (wr_issue) begin
			mem_req   <= 1'b1;
			mem_we    <= 1'b1;
			mem_addr  <= dst;
			mem_wdata <= fifo_out_data;
		end else if (bk_issue) begin
			mem_req   <= 1'b1;
			mem_we    <= 1'b1;
			mem_addr  <= info_addr + {27'h0, idx, 2'h0};
			mem_wdata <= back_word;
		end
	end

	// state sequence
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= S_IDLE;
		end else begin
			unique case (state)
				S_IDLE:  if (activate) state <= S_VEC;
				S_VEC:   if (mem_ack) state <= S_INFO;
				S_INFO:  if (mem_ack && (idx == INFO_CNT)) state <= S_READ;
				S_READ:  if (rd_turn) state <= S_WRITE;
				S_WRITE: begin
					if (block_end) begin
						state <= S_BACK;
					end else if (wr_turn) begin
						state <= S_READ;
					end
				end
				S_BACK:  if (back_done) state <= S_IDLE;
			endcase
		end
	end

	// transfer information and counters
	always_ff @(posedge core_clk) begin
		if (srst) begin
			idx                <= 3'h0;
			info_addr          <= 32'h0;
			mode               <= 5'h0;
			src                <= 32'h0;
			dst                <= 32'h0;
			src_init           <= 32'h0;
			dst_init           <= 32'h0;
			block_size_counter <= 16'h0;
			block_size_reload  <= 16'h0;
			block_count        <= 16'h0;
			rd_left            <= 16'h0;
		end else begin
			if ((state == S_VEC) && mem_ack) begin
				info_addr <= mem_rdata;
				idx       <= INFO_MODE;
			end
			if ((state == S_INFO) && mem_ack) begin
				idx <= idx + 3'h1;
				unique case (idx)
					INFO_MODE: mode <= mem_rdata[4:0];
					INFO_SRC:  begin
						src      <= mem_rdata;
						src_init <= mem_rdata;
					end
					INFO_DST:  begin
						dst      <= mem_rdata;
						dst_init <= mem_rdata;
					end
					INFO_SIZE: begin
						block_size_reload  <= mem_rdata[31:16];
						block_size_counter <= mem_rdata[15:0];
					end
					default:   block_count <= mem_rdata[15:0];
				endcase
			end
			if ((state == S_INFO) && mem_ack && (idx == INFO_CNT)) begin
				rd_left <= block_size_counter;
			end
			// rd_left keeps counting across read/write turns so the FIFO never over-reads
			if (fifo_push) begin
				src     <= step(src, mode[MODE_SM_LSB +: 2]);
				rd_left <= rd_left - 16'h1;
			end
			if ((state == S_WRITE) && mem_ack) begin
				dst                <= step(dst, mode[MODE_DM_LSB +: 2]);
				block_size_counter <= block_size_counter - 16'h1;
			end
			if (block_end) begin
				block_count        <= block_count - 16'h1;
				block_size_counter <= block_size_reload;
				idx                <= INFO_SRC;
				if (area_dst) begin
					dst <= dst_init;
				end else begin
					src <= src_init;
				end
			end
			if (bk_issue) begin
				idx <= idx + 3'h1;
			end
		end
	end

	// checks on the sequence
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	flag_set_a: assert property (conv_rise |=> conversion_end_flag)
		else $error("flag not set by conversion end");
	vec_first_a: assert property (activate |=> mem_req && !mem_we && (mem_addr == $past(vec_addr)))
		else $error("vector not read first");
	info_from_a: assert property ((state == S_VEC) && mem_ack |=> !mem_we && (mem_addr == $past(mem_rdata)))
		else $error("info not fetched from vector address");
	unit_dec_a: assert property ((state == S_WRITE) && mem_ack
		|=> block_size_counter == $past(block_size_counter) - 16'h1)
		else $error("size counter not decremented");
	block_dec_a: assert property (block_end |=> block_count == $past(block_count) - 16'h1)
		else $error("block count not decremented");
	wback_a: assert property (block_end |=> (state == S_BACK) ##1 (mem_req && mem_we
		&& (mem_addr == info_addr + WORD_STEP)))
		else $error("write-back not started");
	more_blk_a: assert property (back_done && !last_blk && !conv_rise && !ctrl_wr
		|=> !conversion_end_flag && transfer_enable_bit && !cpu_irq)
		else $error("non-final block end wrong");
	last_blk_a: assert property (back_done && last_blk && !ctrl_wr
		|=> !transfer_enable_bit && conversion_end_flag && cpu_irq && (state == S_IDLE))
		else $error("final block end wrong");
	reload_a: assert property (block_end |=> block_size_counter == $past(block_size_reload))
		else $error("size counter not reloaded");
	restore_a: assert property (block_end && area_dst |=> dst == $past(dst_init))
		else $error("block-area address not restored");

	act_c:   cover property (activate ##[1:300] block_end);
	final_c: cover property (back_done && last_blk);
	more_c:  cover property (back_done && !last_blk);
	full_c:  cover property ((state == S_READ) && !fifo_in_ready);

endmodule : block_transfer_dma

// ### src/bdma_pkg.sv
// constants and types of the block transfer controller
// assumes 32-bit words on the memory side and a word-wide register port
package bdma_pkg;

	// widths and depths
	localparam int          DATA_W      = 32;
	localparam int          FIFO_DEPTH  = 16;

	// register offsets on the register port
	localparam logic [3:0]  REG_CTRL    = 4'h0;
	localparam logic [3:0]  REG_VBASE   = 4'h4;
	localparam logic [3:0]  REG_VNUM    = 4'h8;
	localparam logic [3:0]  REG_STATUS  = 4'hC;

	// control register fields
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          CTRL_FLAG_BIT = 1;

	// reset values
	localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
	localparam logic [7:0]  VNUM_RESET  = 8'h00;

	// transfer information layout, word index from its storage address
	localparam logic [2:0]  INFO_MODE   = 3'h0;
	localparam logic [2:0]  INFO_SRC    = 3'h1;
	localparam logic [2:0]  INFO_DST    = 3'h2;
	localparam logic [2:0]  INFO_SIZE   = 3'h3;
	localparam logic [2:0]  INFO_CNT    = 3'h4;
	localparam logic [2:0]  INFO_END    = 3'h5;

	// mode word fields
	localparam int          MODE_SM_LSB   = 0;
	localparam int          MODE_DM_LSB   = 2;
	localparam int          MODE_AREA_BIT = 4;

	// address progression codes
	localparam logic [1:0]  AM_FIXED    = 2'h0;
	localparam logic [1:0]  AM_INC      = 2'h1;
	localparam logic [1:0]  AM_DEC      = 2'h2;

	// byte step between words
	localparam logic [31:0] WORD_STEP   = 32'h0000_0004;

	// controller states, one-hot
	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_VEC   = 6'h02,
		S_INFO  = 6'h04,
		S_READ  = 6'h08,
		S_WRITE = 6'h10,
		S_BACK  = 6'h20
	} state_t;

endpackage : bdma_pkg

// ### src/word_fifo.sv
// first-in first-out buffer between the source reads and destination writes
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
module word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	// honest full and empty from the fill count
	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = store[rd_ptr];

	// storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : word_fifo

// ### src/edge_sync.sv
// two-flop synchroniser with rising-edge pulse for an outside level
// assumes the input may change at any time relative to core_clk
`timescale 1ns/10ps
module edge_sync (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      rise
);
	logic meta;
	logic sync;
	logic sync_d;

	// first flop feeds only the second
	always_ff @(posedge core_clk) begin
		if (srst) begin
			meta   <= 1'b0;
			sync   <= 1'b0;
			sync_d <= 1'b0;
		end else begin
			meta   <= async_in;
			sync   <= meta;
			sync_d <= sync;
		end
	end

	assign rise = sync && !sync_d;

endmodule : edge_sync

// ### dv/mem_model.sv
// memory partner: word array that answers each request with a one-cycle ack
// assumes one outstanding request and word addresses below 0x400
`timescale 1ns/10ps
module mem_model (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [31:0] mem [0:255];

	// ack after a random wait when slow; read data only beside the ack
	always @(posedge core_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata; // no stale data between answers
		if (srst) begin
			mem_rdata <= 32'h0000_0000;
		end else if (mem_req && !mem_ack && (!slow || $urandom % 3 == 0)) begin
			mem_ack <= 1'b1;
			if (mem_we)
				mem[mem_addr[9:2]] <= mem_wdata;
			else
				mem_rdata <= mem[mem_addr[9:2]];
		end
	end
endmodule : mem_model

// ### dv/tb_block_transfer_dma.sv
// self-checking bench: random block transfers against a memory partner
// assumes the package, FIFO, synchroniser and controller compiled before it
`timescale 1ns/10ps
module tb_block_transfer_dma import bdma_pkg::*;;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        conv_done = 1'b0;
	logic        slow = 1'b0;
	logic        mem_req, mem_we, mem_ack, cpu_irq, area, last;
	logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, rd_val, src, dst, dst0;
	logic [31:0] exp_mem [0:255];
	logic [31:0] log_q [$];
	logic [15:0] n, nb;
	logic [1:0]  sm, dm;
	logic [7:0]  vnum;
	int          errors = 0;
	int          tests_run = 0;

	always #5 core_clk = ~core_clk;

	block_transfer_dma u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .cpu_irq(cpu_irq));
	mem_model u_mem (.core_clk(core_clk), .srst(srst), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// log of finished requests: write flag in bit 31, address below
	always @(posedge core_clk) begin
		if (mem_req && mem_ack)
			log_q.push_back({mem_we, mem_addr[30:0]});
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic reg_read(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask : reg_read

	task automatic pulse_conv();
		@(posedge core_clk);
		conv_done <= 1'b1;
		repeat (4) @(posedge core_clk);
		conv_done <= 1'b0;
	endtask : pulse_conv

	// next address of one progression code
	function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] m);
		return (m == AM_INC) ? a + WORD_STEP : (m == AM_DEC) ? a - WORD_STEP : a;
	endfunction : step

	// hang guard
	initial begin
		#500000;
		errors++;
		report_and_stop();
	end

	initial begin
		rd_val = $urandom(32'h8A049A7C);
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		// reset values and an unmapped place
		reg_read(REG_CTRL);
		check("ctrl reset", rd_val, 32'h0000_0000);
		reg_read(REG_VBASE);
		check("vbase reset", rd_val, VBASE_RESET);
		reg_read(REG_VNUM);
		check("vnum reset", rd_val, {24'h0, VNUM_RESET});
		reg_read(REG_STATUS);
		check("state reset", {26'h0, rd_val[5:0]}, {26'h0, S_IDLE});
		reg_write(4'h2, 32'hFFFF_FFFF);
		reg_read(4'h2);
		check("unmapped", rd_val, 32'h0000_0000);
		// event with transfers disabled goes straight to the cpu
		pulse_conv();
		repeat (8) @(posedge core_clk);
		check("irq direct", 32'(cpu_irq), 32'h1);
		check("no request", 32'(mem_req), 32'h0);
		reg_read(REG_CTRL);
		check("flag set", rd_val, 32'h2);
		reg_write(REG_CTRL, 32'h0);
		@(posedge core_clk);
		check("irq cleared", 32'(cpu_irq), 32'h0);
		// transfers: fifo overflow size, empty block, then random sizes
		for (int k = 0; k < 8; k++) begin
			n = (k == 0) ? 16'd17 : (k == 1) ? 16'd0 : 16'(1 + $urandom % 17);
			nb = 16'(1 + $urandom % 3);
			sm = 2'($urandom % 3);
			dm = 2'($urandom % 3);
			area = 1'($urandom);
			vnum = 8'($urandom % 16);
			slow <= (k == 0) || 1'($urandom);
			src = 32'h300;
			dst0 = (dm == AM_DEC) ? 32'h0FC : 32'h0;
			dst = dst0;
			for (int i = 0; i < 256; i++)
				exp_mem[i] = $urandom;
			exp_mem[64 + vnum] = 32'h200;
			exp_mem[128] = {27'h0, area, dm, sm};
			exp_mem[129] = src;
			exp_mem[130] = dst;
			exp_mem[131] = {n, n};
			exp_mem[132] = {16'h0, nb};
			for (int i = 0; i < 256; i++)
				u_mem.mem[i] = exp_mem[i];
			reg_write(REG_VBASE, 32'h100);
			reg_write(REG_VNUM, {24'h0, vnum});
			reg_write(REG_CTRL, 32'h1);
			for (int b = 0; b < nb; b++) begin
				log_q.delete();
				pulse_conv();
				for (int w = 0; w < 3000 && !(log_q.size() > 0 && log_q[$] === 32'h8000_0210); w++)
					@(posedge core_clk);
				repeat (3) @(posedge core_clk);
				check("block done", (log_q.size() > 0) ? log_q[$] : 32'h0000_0000, 32'h8000_0210);
				check("vector read", log_q[0], 32'h100 + 32'(4 * vnum));
				for (int i = 0; i < 5; i++)
					check("info read", log_q[1 + i], 32'h200 + 32'(4 * i));
				for (int i = 0; i < 4; i++)
					check("write-back", log_q[log_q.size() - 4 + i], 32'h8000_0204 + 32'(4 * i));
				// expected copy of one block and its write-back
				for (int u = 0; u < n; u++) begin
					exp_mem[dst[9:2]] = exp_mem[src[9:2]];
					src = step(src, sm);
					dst = step(dst, dm);
				end
				if (area)
					dst = dst0;
				else
					src = 32'h300;
				exp_mem[129] = src;
				exp_mem[130] = dst;
				exp_mem[131] = {n, n};
				exp_mem[132] = {16'h0, 16'(nb - 1 - b)};
				last = (b == nb - 1);
				reg_read(REG_CTRL);
				check("ctrl after block", rd_val, last ? 32'h2 : 32'h1);
				check("irq after block", 32'(cpu_irq), 32'(last));
				reg_read(REG_STATUS);
				check("status", {rd_val[31:16], 10'h0, rd_val[5:0]}, {16'(nb - 1 - b), 16'h0001});
			end
			reg_write(REG_CTRL, 32'h0);
			@(posedge core_clk);
			check("irq handled", 32'(cpu_irq), 32'h0);
			for (int i = 0; i < 256; i++)
				check("memory", u_mem.mem[i], exp_mem[i]);
		end
		// second reset in mid-run, cutting an activation in progress
		reg_write(REG_CTRL, 32'h1);
		pulse_conv();
		repeat (12) @(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		check("req after reset", 32'(mem_req), 32'h0);
		check("irq after reset", 32'(cpu_irq), 32'h0);
		reg_read(REG_CTRL);
		check("ctrl second reset", rd_val, 32'h0000_0000);
		reg_read(REG_STATUS);
		check("status second reset", {rd_val[31:16], 10'h0, rd_val[5:0]}, 32'h0000_0001);
		report_and_stop();
	end
endmodule : tb_block_transfer_dma
